// ---- plm_board.sv ----
// Board model: register clock pin and the far ends of the macrocell pins.
`timescale 1ns/1ps
module plm_board (
  input wire logic pclk,
  input wire logic por_busy,
  input wire logic tick,
  input wire logic [7:0] io_pin_out,
  input wire logic [7:0] io_pin_oe,
  input wire logic [7:0] pin_pull_lo,
  output logic clk_pin,
  output logic [7:0] io_pin_in,
  output logic [7:0] io_pin_driven
);
  logic [1:0] ph_r = 2'h0;
  // clock held still
  // A tick gives one two-cycle clock pulse, never within the power-up interval.
  always @(posedge pclk) begin
    if (ph_r != 2'h0) begin
      ph_r <= ph_r - 2'h1;
    end else if (tick && !por_busy) begin
      ph_r <= 2'h3;
    end
  end
  assign clk_pin = ph_r[1];
  // A driven pin shows the device level; a released pin is pulled low where the bench asks.
  // Any other released pin is left undriven, with the inverse level on its wire.
  assign io_pin_in = (io_pin_oe & io_pin_out) | (~io_pin_oe & ~pin_pull_lo & ~io_pin_out);
  assign io_pin_driven = io_pin_oe | pin_pull_lo;
endmodule

// ---- plm_macrocells.sv ----
// Output macrocells, product term array and APB register file of the logic array.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module plm_macrocells (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] in_pin,
  input wire logic [11:0] in_pin_driven,
  input wire logic clk_pin,
  input wire logic oe_pin_n,
  input wire logic [7:0] io_pin_in,
  input wire logic [7:0] io_pin_driven,
  output logic [7:0] io_pin_out,
  output logic [7:0] io_pin_oe,
  output logic por_busy
);
  // Register state.
  plm_pkg::plm_mode_t mode_r, mode_nxt;
  logic sec_r, sec_nxt;
  logic [15:0] mccfg_r, mccfg_nxt;
  logic [63:0] sig_r, sig_nxt;
  logic [5:0] pt_addr_r, pt_addr_nxt;
  logic [7:0] q_r, q_nxt;
  logic clk_pin_q_r, clk_pin_q_nxt;
  logic [7:0] por_cnt_r, por_cnt_nxt;
  logic por_busy_r, por_busy_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [7:0] io_out_r, io_out_nxt;
  logic [7:0] io_oe_r, io_oe_nxt;
  plm_pkg::plm_pt_mask_t pt_mem [plm_pkg::N_PT];
  logic pt_wr_true, pt_wr_comp;

  // Combinational nets.
  logic [plm_pkg::N_IN-1:0] in_eff;
  logic [7:0] pin_eff, fb;
  logic [plm_pkg::N_ARR-1:0] arr;
  logic [plm_pkg::N_PT-1:0] pt_val;
  logic [7:0] sum8, sum7, pt_oe, cell_out, cell_oe;
  logic acc, wr_fire, clk_rise, is_reg_mode;

  assign is_reg_mode = (mode_r == plm_pkg::PLM_MODE_REG);

  // Pull-ups: an input that nobody drives is seen by the array as one.
  // pull-up on inputs
  assign in_eff = (in_pin & in_pin_driven) | ~in_pin_driven;

  // Pin level seen by the array: own drive first, then the board, then the pull-up.
  genvar m;
  generate
    for (m = 0; m < plm_pkg::N_MC; m++) begin : g_cell
      plm_pkg::plm_mc_kind_t kind;
      logic [7:0] pts;
      assign kind = plm_pkg::plm_mc_kind_t'(mccfg_r[2*m +: 2]);
      assign pts = pt_val[m*plm_pkg::PT_PER_MC +: plm_pkg::PT_PER_MC];
      assign pin_eff[m] = io_oe_r[m] ? io_out_r[m] :
                          (io_pin_driven[m] ? io_pin_in[m] : 1'b1);
      // Registered cells feed back their register, others feed back the pin.
      assign fb[m] = (is_reg_mode && kind == plm_pkg::PLM_MC_REG_OUT) ? q_r[m] : pin_eff[m];
      assign sum8[m] = |pts;
      assign sum7[m] = |pts[7:1];
      assign pt_oe[m] = pts[0];

      // Per-cell output value and enable by global mode and cell kind.
      always_comb begin
        cell_out[m] = ~sum8[m];
        cell_oe[m] = 1'b0;
        case (mode_r)
          plm_pkg::PLM_MODE_REG: begin
            case (kind)
              plm_pkg::PLM_MC_REG_OUT: begin
                cell_out[m] = ~q_r[m];
                cell_oe[m] = ~oe_pin_n;
              end
              plm_pkg::PLM_MC_INPUT: begin
                cell_oe[m] = 1'b0;
              end
              default: begin
                cell_out[m] = ~sum7[m];
                cell_oe[m] = pt_oe[m];
              end
            endcase
          end
          plm_pkg::PLM_MODE_COMPLEX: begin
            cell_out[m] = ~sum7[m];
            cell_oe[m] = (kind == plm_pkg::PLM_MC_INPUT) ? 1'b0 : pt_oe[m];
          end
          default: begin
            cell_out[m] = ~sum8[m];
            cell_oe[m] = (kind != plm_pkg::PLM_MC_INPUT);
          end
        endcase
      end
    end
  endgenerate

  assign arr = {fb, in_eff};

  // Each product term is the AND of its selected true and complemented array inputs.
  genvar p;
  generate
    for (p = 0; p < plm_pkg::N_PT; p++) begin : g_pt
      assign pt_val[p] = &((~pt_mem[p].true_m | arr) & (~pt_mem[p].comp_m | ~arr));
    end
  endgenerate

  // Bus handshake: one wait cycle, writes act at the edge that sees pready high.
  assign acc = psel & penable & ~pready_r;
  assign wr_fire = psel & penable & pready_r & pwrite;
  assign clk_rise = clk_pin & ~clk_pin_q_r;

  // Next values of the register file, macrocell registers and pins.
  always_comb begin
    mode_nxt = mode_r;
    sec_nxt = sec_r;
    mccfg_nxt = mccfg_r;
    sig_nxt = sig_r;
    pt_addr_nxt = pt_addr_r;
    q_nxt = q_r;
    clk_pin_q_nxt = clk_pin;
    por_cnt_nxt = por_cnt_r;
    prdata_nxt = prdata_r;
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    pt_wr_true = 1'b0;
    pt_wr_comp = 1'b0;
    io_out_nxt = cell_out;
    io_oe_nxt = cell_oe;

    // Read data and error answer are prepared in the first access cycle.
    if (acc) begin
      prdata_nxt = plm_pkg::DATA_ZERO;
      case (paddr)
        plm_pkg::ADDR_CTRL: begin
          prdata_nxt[plm_pkg::CTRL_MODE_LSB +: 2] = mode_r;
          prdata_nxt[plm_pkg::CTRL_SEC_BIT] = sec_r;
        end
        plm_pkg::ADDR_MCCFG: begin
          prdata_nxt[15:0] = mccfg_r;
        end
        plm_pkg::ADDR_STATUS: begin
          prdata_nxt[plm_pkg::STAT_REG_LSB +: 8] = q_r;
          prdata_nxt[plm_pkg::STAT_PIN_LSB +: 8] = pin_eff;
          prdata_nxt[plm_pkg::STAT_POR_BIT] = por_busy_r;
        end
        plm_pkg::ADDR_PRELOAD: begin
          if (sec_r) begin
            pslverr_nxt = 1'b1;
          end else begin
            prdata_nxt[7:0] = q_r;
          end
        end
        plm_pkg::ADDR_SIG_LO: begin
          prdata_nxt = sig_r[31:0];
        end
        plm_pkg::ADDR_SIG_HI: begin
          prdata_nxt = sig_r[63:32];
        end
        plm_pkg::ADDR_PT_ADDR: begin
          prdata_nxt[5:0] = pt_addr_r;
        end
        plm_pkg::ADDR_PT_TRUE: begin
          if (sec_r && !pwrite) begin
            pslverr_nxt = 1'b1;
          end else begin
            prdata_nxt[plm_pkg::N_ARR-1:0] = pt_mem[pt_addr_r].true_m;
          end
        end
        plm_pkg::ADDR_PT_COMP: begin
          if (sec_r && !pwrite) begin
            pslverr_nxt = 1'b1;
          end else begin
            prdata_nxt[plm_pkg::N_ARR-1:0] = pt_mem[pt_addr_r].comp_m;
          end
        end
        default: begin
          pslverr_nxt = 1'b1;
        end
      endcase
      if (sec_r && pwrite && paddr == plm_pkg::ADDR_PT_TRUE) begin
        pslverr_nxt = 1'b0;
      end
      if (sec_r && pwrite && paddr == plm_pkg::ADDR_PT_COMP) begin
        pslverr_nxt = 1'b0;
      end
    end

    // Macrocell registers load on a rising edge of the clock pin in registered mode.
    // load on clock pin
    if (is_reg_mode && clk_rise) begin
      for (int i = 0; i < plm_pkg::N_MC; i++) begin
        if (plm_pkg::plm_mc_kind_t'(mccfg_r[2*i +: 2]) == plm_pkg::PLM_MC_REG_OUT) begin
          q_nxt[i] = sum8[i];
        end
      end
    end

    // Register writes; the mode holds one of the three legal values only.
    if (wr_fire) begin
      case (paddr)
        plm_pkg::ADDR_CTRL: begin
          case (pwdata[plm_pkg::CTRL_MODE_LSB +: 2])
            2'h1: mode_nxt = plm_pkg::PLM_MODE_COMPLEX;
            2'h2: mode_nxt = plm_pkg::PLM_MODE_REG;
            default: mode_nxt = plm_pkg::PLM_MODE_SIMPLE;
          endcase
          sec_nxt = sec_r | pwdata[plm_pkg::CTRL_SEC_BIT];
        end
        plm_pkg::ADDR_MCCFG: begin
          mccfg_nxt = pwdata[15:0];
        end
        plm_pkg::ADDR_PRELOAD: begin
          if (!sec_r) begin
            q_nxt = pwdata[7:0];
          end
        end
        plm_pkg::ADDR_SIG_LO: begin
          sig_nxt[31:0] = pwdata;
        end
        plm_pkg::ADDR_SIG_HI: begin
          sig_nxt[63:32] = pwdata;
        end
        plm_pkg::ADDR_PT_ADDR: begin
          pt_addr_nxt = pwdata[5:0];
        end
        plm_pkg::ADDR_PT_TRUE: begin
          pt_wr_true = 1'b1;
        end
        plm_pkg::ADDR_PT_COMP: begin
          pt_wr_comp = 1'b1;
        end
        default: begin
          pt_wr_true = 1'b0;
        end
      endcase
    end

    // Macrocell registers are held clear until the power-up interval has run out.
    // clear during power-up
    if (por_cnt_r != 8'h00) begin
      por_cnt_nxt = por_cnt_r - 8'h01;
      q_nxt = 8'h00;
    end
  end

  assign por_busy_nxt = (por_cnt_nxt != 8'h00);

  // State registers; reset clears the macrocell registers and shows pins high and undriven.
  // pins high after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= plm_pkg::PLM_MODE_SIMPLE;
      sec_r <= 1'b0;
      mccfg_r <= plm_pkg::MCCFG_RST;
      sig_r <= {plm_pkg::SIG_RST, plm_pkg::SIG_RST};
      pt_addr_r <= 6'h00;
      q_r <= 8'h00;
      clk_pin_q_r <= 1'b0;
      por_cnt_r <= plm_pkg::POR_CNT_LOAD;
      por_busy_r <= 1'b1;
      prdata_r <= plm_pkg::DATA_ZERO;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      io_out_r <= plm_pkg::PIN_OUT_RST;
      io_oe_r <= 8'h00;
    end else begin
      mode_r <= mode_nxt;
      sec_r <= sec_nxt;
      mccfg_r <= mccfg_nxt;
      sig_r <= sig_nxt;
      pt_addr_r <= pt_addr_nxt;
      q_r <= q_nxt;
      clk_pin_q_r <= clk_pin_q_nxt;
      por_cnt_r <= por_cnt_nxt;
      por_busy_r <= por_busy_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      io_out_r <= io_out_nxt;
      io_oe_r <= io_oe_nxt;
    end
  end

  // Product term memory; erased terms have no inputs selected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < plm_pkg::N_PT; i++) begin
        pt_mem[i] <= '0;
      end
    end else begin
      if (pt_wr_true) begin
        pt_mem[pt_addr_r].true_m <= pwdata[plm_pkg::N_ARR-1:0];
      end
      if (pt_wr_comp) begin
        pt_mem[pt_addr_r].comp_m <= pwdata[plm_pkg::N_ARR-1:0];
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign io_pin_out = io_out_r;
  assign io_pin_oe = io_oe_r;
  assign por_busy = por_busy_r;
endmodule

// ---- plm_macrocells_props.sv ----
// Port checks for the macrocell block, bound to its top module.
`timescale 1ns/1ps
module plm_macrocells_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] io_pin_out,
  input wire logic [7:0] io_pin_oe,
  input wire logic por_busy
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic sec_r;
  logic sec_nxt;
  logic wait_w;
  // An access phase that is still waiting for its answer.
  assign wait_w = psel && penable && !pready;
  // Counts power-up cycles and remembers a completed write of the security bit.
  always_comb begin
    cnt_nxt = por_busy ? cnt_r + 8'h01 : cnt_r;
    sec_nxt = sec_r || (psel && penable && pready && pwrite && paddr == plm_pkg::ADDR_CTRL
      && pwdata[plm_pkg::CTRL_SEC_BIT]);
  end
  // Registers the helper state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      sec_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sec_r <= sec_nxt;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  por_len_a: assert property ($fell(por_busy) |-> cnt_r inside {[8'h76:8'h7A]})
    else $error("power-up interval has the wrong length");
  por_once_a: assert property (!por_busy |=> !por_busy)
    else $error("power-up interval restarted without reset");
  reset_pins_a: assert property ($rose(presetn) |-> io_pin_out == 8'hFF && io_pin_oe == 8'h00)
    else $error("pins not high and released after reset");
  one_wait_a: assert property (wait_w |=> pready)
    else $error("answer not one cycle after the access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  sig_open_a: assert property (wait_w && (paddr == plm_pkg::ADDR_SIG_LO ||
    paddr == plm_pkg::ADDR_SIG_HI) |=> !pslverr)
    else $error("signature access refused");
  sec_preload_a: assert property (sec_r && wait_w && paddr == plm_pkg::ADDR_PRELOAD |=> pslverr)
    else $error("preload allowed on a secured part");
endmodule
bind plm_macrocells plm_macrocells_props plm_macrocells_props_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .io_pin_out, .io_pin_oe, .por_busy);

// ---- plm_pkg.sv ----
// Constants, enumerations and carrier types for the programmable logic macrocell block.
// Summary of operation
// - Power-up reset clears every macrocell register.
// - Registered pins show high after reset.
// - Preload forces any register to one or zero.
// - Sixty-four signature bits, always readable and writable.
// - Secured part refuses verify readback and preload.
// - Each macrocell: registered, I/O, output, input.
// - Exactly one of three global modes.
// - Registered cell: clock pin, enable pin, eight terms.
// - Combinatorial cell: one enable term, seven sum; in simple mode eight sum, always enabled.
// - Input cell never drives its pin.
package plm_pkg;
  localparam int N_MC = 8;
  localparam int N_IN = 12;
  localparam int N_ARR = 20;
  localparam int N_PT = 64;
  localparam int PT_PER_MC = 8;
  // Power-up reset interval, typical figure, rounded up to whole clock cycles.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int POR_TIME_NS = 600;
  localparam int POR_CYCLES = (POR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] POR_CNT_LOAD = 8'(POR_CYCLES);
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MCCFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PRELOAD = 8'h0C;
  localparam logic [7:0] ADDR_SIG_LO = 8'h10;
  localparam logic [7:0] ADDR_SIG_HI = 8'h14;
  localparam logic [7:0] ADDR_PT_ADDR = 8'h18;
  localparam logic [7:0] ADDR_PT_TRUE = 8'h1C;
  localparam logic [7:0] ADDR_PT_COMP = 8'h20;
  // Field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEC_BIT = 4;
  localparam int STAT_REG_LSB = 0;
  localparam int STAT_PIN_LSB = 8;
  localparam int STAT_POR_BIT = 16;
  // Reset values.
  localparam logic [15:0] MCCFG_RST = 16'hFFFF;
  localparam logic [7:0] PIN_OUT_RST = 8'hFF;
  localparam logic [31:0] SIG_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {PLM_MODE_SIMPLE, PLM_MODE_COMPLEX, PLM_MODE_REG} plm_mode_t;
  typedef enum logic [1:0] {PLM_MC_REG_OUT, PLM_MC_COMB_IO, PLM_MC_COMB_OUT,
                            PLM_MC_INPUT} plm_mc_kind_t;

  // One product term: which array inputs it takes true and which complemented.
  typedef struct packed {
    logic [N_ARR-1:0] comp_m;
    logic [N_ARR-1:0] true_m;
  } plm_pt_mask_t;
endpackage

// ---- test_programmable_logic_macrocells.sv ----
// Self-checking bench for the macrocell block with its board model.
`timescale 1ns/1ps
module test_programmable_logic_macrocells;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clk_pin, oe_pin_n, por_busy, tick;
  logic [7:0] paddr, io_pin_in, io_pin_driven, io_pin_out, io_pin_oe, pin_pull_lo;
  logic [31:0] pwdata, prdata;
  logic [11:0] in_pin, in_pin_driven;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int i;
  plm_macrocells plm_macrocells_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .in_pin, .in_pin_driven, .clk_pin, .oe_pin_n, .io_pin_in,
    .io_pin_driven, .io_pin_out, .io_pin_oe, .por_busy);
  plm_board plm_board_i (.pclk, .por_busy, .tick, .io_pin_out, .io_pin_oe, .pin_pull_lo,
    .clk_pin, .io_pin_in, .io_pin_driven);
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compares one value and counts it.
  task automatic chk(input string w, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", w, exp, got);
    end
  endtask
  // One APB transfer; a read compares the bits in m, every transfer its error flag.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e,
                     input logic [31:0] m);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    chk("error flag", {31'h0, e}, {31'h0, pslverr});
    if (!w) chk("read data", d & m, prdata & m);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // Free-running system clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Cuts a hung run short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  // Main sequence of transfers and pin checks.
  initial begin
    {psel, penable, pwrite, tick, presetn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    in_pin = 12'h000;
    in_pin_driven = 12'h000;
    pin_pull_lo = 8'h00;
    oe_pin_n = 1'b1;
    repeat (16) @(posedge pclk);
    chk("reset pins", 32'h00FF, {16'h0, io_pin_oe, io_pin_out});
    presetn <= 1'b1;
    while (por_busy !== 1'b0) @(posedge pclk);
    acc(1'b0, plm_pkg::ADDR_STATUS, 32'h0000_FF00, 1'b0, 32'h0001_FFFF);
    acc(1'b1, plm_pkg::ADDR_SIG_LO, 32'h1357_9BDF, 1'b0, 32'h0);
    acc(1'b0, plm_pkg::ADDR_SIG_LO, 32'h1357_9BDF, 1'b0, ~32'h0);
    acc(1'b1, 8'h40, 32'h0, 1'b1, 32'h0);
    // Term 8m follows input 4+m for cell m; every other term never fires.
    for (i = 0; i < 64; i++) begin
      acc(1'b1, plm_pkg::ADDR_PT_ADDR, 32'(i), 1'b0, 32'h0);
      acc(1'b1, plm_pkg::ADDR_PT_TRUE, (i % 8 == 0) ? 32'h1 << (i / 8 + 4) : 32'h1, 1'b0, 32'h0);
      acc(1'b1, plm_pkg::ADDR_PT_COMP, (i % 8 == 0) ? 32'h0 : 32'h1, 1'b0, 32'h0);
    end
    acc(1'b0, plm_pkg::ADDR_PT_TRUE, 32'h1, 1'b0, 32'h000F_FFFF);
    acc(1'b1, plm_pkg::ADDR_MCCFG, 32'h0, 1'b0, 32'h0);
    acc(1'b1, plm_pkg::ADDR_CTRL, 32'h2, 1'b0, 32'h0);
    oe_pin_n <= 1'b0;
    in_pin <= 12'h050;
    in_pin_driven <= 12'h0FF;
    acc(1'b1, plm_pkg::ADDR_PRELOAD, 32'hA5, 1'b0, 32'h0);
    acc(1'b0, plm_pkg::ADDR_PRELOAD, 32'hA5, 1'b0, 32'hFF);
    chk("preload pins", 32'hFF5A, {16'h0, io_pin_oe, io_pin_out});
    tick <= 1'b1;
    @(posedge pclk);
    tick <= 1'b0;
    repeat (8) @(posedge pclk);
    acc(1'b0, plm_pkg::ADDR_STATUS, 32'h0AF5, 1'b0, 32'hFFFF);
    chk("clocked pins", 32'hFF0A, {16'h0, io_pin_oe, io_pin_out});
    acc(1'b1, plm_pkg::ADDR_MCCFG, 32'hE4E4, 1'b0, 32'h0);
    acc(1'b0, plm_pkg::ADDR_MCCFG, 32'hE4E4, 1'b0, 32'hFFFF);
    for (i = 0; i < 4; i++) begin
      acc(1'b1, plm_pkg::ADDR_CTRL, 32'(i), 1'b0, 32'h0);
      chk("mode enables", (i == 1 || i == 2) ? 32'h75 : 32'h77, {24'h0, io_pin_oe});
    end
    acc(1'b1, plm_pkg::ADDR_CTRL, 32'h2, 1'b0, 32'h0);
    oe_pin_n <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("disabled pins", 32'h6466, {16'h0, io_pin_oe, io_pin_out & 8'h66});
    acc(1'b1, plm_pkg::ADDR_PRELOAD, 32'h3C, 1'b0, 32'h0);
    acc(1'b1, plm_pkg::ADDR_CTRL, 32'h12, 1'b0, 32'h0);
    acc(1'b0, plm_pkg::ADDR_CTRL, 32'h12, 1'b0, 32'h13);
    acc(1'b1, plm_pkg::ADDR_PRELOAD, 32'hC3, 1'b1, 32'h0);
    pin_pull_lo <= 8'h01;
    acc(1'b0, plm_pkg::ADDR_STATUS, 32'hFE3C, 1'b0, 32'hFFFF);
    acc(1'b0, plm_pkg::ADDR_PT_COMP, 32'h0, 1'b1, ~32'h0);
    acc(1'b1, plm_pkg::ADDR_SIG_HI, 32'h0F0F_0F0F, 1'b0, 32'h0);
    acc(1'b0, plm_pkg::ADDR_SIG_HI, 32'h0F0F_0F0F, 1'b0, ~32'h0);
    end_sim();
  end
endmodule
